/* File: logic/hsie_pkg.sv */
// Constants for the host serial interrupt enable block.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package hsie_pkg;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] HSIE_OFS_CTRL = 8'h00;
   localparam logic [7:0] HSIE_OFS_MODE = 8'h04;
   localparam logic [7:0] HSIE_OFS_STAT = 8'h08;
   localparam logic [7:0] HSIE_OFS_MASK = 8'h0c;

   // ----------------------------------------
   // Field layout
   // ----------------------------------------
   localparam int HSIE_EN_W   = 4;
   localparam int HSIE_EN_LSB = 3;
   localparam int HSIE_MODE_DIRECT_BIT = 0;
   // Index 0..3 are register bits 3..6
   localparam logic [3:0] HSIE_EN_IS_CH3 = 4'he;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [3:0] HSIE_EN_RST   = 4'h0;
   localparam logic       HSIE_MODE_RST = 1'b0;
   localparam logic [3:0] HSIE_STAT_RST = 4'h0;
   localparam logic [3:0] HSIE_MASK_RST = 4'h0;

   // ----------------------------------------
   // Serial interrupt frame timing: slot numbers, slot phases and start length in link clocks
   // ----------------------------------------
   localparam logic [3:0] HSIE_SLOT_INT11 = 4'hb;
   localparam logic [3:0] HSIE_SLOT_INT6  = 4'h6;
   localparam logic [3:0] HSIE_SLOT_INT9  = 4'h9;
   localparam logic [3:0] HSIE_SLOT_INT10 = 4'ha;
   localparam logic [3:0] HSIE_START_MIN_CLKS = 4'h4;
   localparam logic [1:0] HSIE_SLOT_LAST_PHASE = 2'h2;
   localparam logic [3:0] HSIE_LAST_SLOT = 4'hf;

   typedef enum logic [1:0] {
      HSIE_FR_IDLE,
      HSIE_FR_TURN,
      HSIE_FR_SLOTS
   } hsie_frame_t;

endpackage

/* File: logic/hsie_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/1ps
module hsie_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff    <= '0;
         s2_ff    <= '0;
         s3_ff    <= '0;
         sync_out <= '0;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               sync_out[i] <= s3_ff[i];
            end
         end
      end
   end

endmodule

/* File: logic/hsie_top.sv */
// Host serial interrupt enables with APB registers and serial IRQ slot driver.
// Assumes output-buffer-full flags come from host-interface logic on pclk;
// the link clock, serial IRQ line and LPC resets arrive asynchronously.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module hsie_top
   import hsie_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        out_buffer_full_ch3,
   input  wire logic        out_buffer_full_ch2,
   input  wire logic        lpc_reset_n,
   input  wire logic        lpc_sw_reset,
   input  wire logic        lclk,
   input  wire logic        serirq_i,
   output      logic        serirq_o,
   output      logic        serirq_oe,
   output      logic        irq
);

   // ----------------------------------------
   // Asynchronous inputs
   // ----------------------------------------
   logic [3:0] sync_vec;
   logic       lclk_s, sio_s, lpc_rst_s;

   hsie_sync #(
      .WIDTH (4)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({lclk, serirq_i, ~lpc_reset_n, lpc_sw_reset}),
      .sync_out (sync_vec)
   );

   assign lclk_s    = sync_vec[3];
   assign sio_s     = sync_vec[2];
   assign lpc_rst_s = sync_vec[1] | sync_vec[0];

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic        setup, done, wr_done, rd_done;
   logic        hit_ctrl, hit_mode, hit_stat, hit_mask, mapped;
   logic        direct_ff;
   logic [3:0]  en_ff, arm_ff, stat_ff, mask_ff, req_ff;
   logic [3:0]  obf_vec, obf_fall;
   logic [1:0]  obf_prev_ff;

   assign setup    = psel & ~penable;
   assign done     = psel & penable & pready;
   assign hit_ctrl = (paddr == HSIE_OFS_CTRL);
   assign hit_mode = (paddr == HSIE_OFS_MODE);
   assign hit_stat = (paddr == HSIE_OFS_STAT);
   assign hit_mask = (paddr == HSIE_OFS_MASK);
   assign mapped   = hit_ctrl | hit_mode | hit_stat | hit_mask;
   // Only the APB port sets the enables; LPC resets and flag falls can only clear them
   assign wr_done  = done & pwrite & mapped & pstrb[0];
   assign rd_done  = done & ~pwrite & mapped;

   // One wait-free answer: prepared in setup, presented in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
         prdata  <= '0;
         if (!pwrite) begin
            unique case (1'b1)
               hit_ctrl: prdata[HSIE_EN_LSB +: HSIE_EN_W] <= en_ff;
               hit_mode: prdata[HSIE_MODE_DIRECT_BIT]      <= direct_ff;
               hit_stat: prdata[HSIE_EN_LSB +: HSIE_EN_W] <= stat_ff;
               hit_mask: prdata[HSIE_EN_LSB +: HSIE_EN_W] <= mask_ff;
               default:  prdata                           <= '0;
            endcase
         end
      end else if (done) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ----------------------------------------
   // Output buffer full tracking
   // ----------------------------------------
   assign obf_vec = {out_buffer_full_ch3, out_buffer_full_ch3,
                     out_buffer_full_ch3, out_buffer_full_ch2};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         obf_prev_ff <= 2'h0;
      end else begin
         obf_prev_ff <= {out_buffer_full_ch3, out_buffer_full_ch2};
      end
   end

   always_comb begin
      for (int i = 0; i < HSIE_EN_W; i++) begin
         if (HSIE_EN_IS_CH3[i]) begin
            obf_fall[i] = obf_prev_ff[1] & ~out_buffer_full_ch3;
         end else begin
            obf_fall[i] = obf_prev_ff[0] & ~out_buffer_full_ch2;
         end
      end
   end

   // ----------------------------------------
   // Enable bits
   // ----------------------------------------
   logic [3:0] wr_en_bits, nxt_en, nxt_arm;

   assign wr_en_bits = pwdata[HSIE_EN_LSB +: HSIE_EN_W];

   always_comb begin
      nxt_en  = en_ff;
      nxt_arm = arm_ff;
      if (rd_done && hit_ctrl) begin
         // Arm from the value software was shown, not from a later flag clear
         nxt_arm = arm_ff | ~prdata[HSIE_EN_LSB +: HSIE_EN_W];
      end
      if (wr_done && hit_ctrl) begin
         for (int i = 0; i < HSIE_EN_W; i++) begin
            if (!wr_en_bits[i]) begin
               nxt_en[i] = 1'b0;
            end else if (arm_ff[i]) begin
               nxt_en[i] = 1'b1;
            end
         end
         // A read is consumed by the next write, so a stale read cannot set a bit
         nxt_arm = '0;
      end
      if (!direct_ff) begin
         nxt_en = nxt_en & ~obf_fall;
      end
      if (lpc_rst_s) begin
         nxt_en  = HSIE_EN_RST;
         nxt_arm = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_ff  <= HSIE_EN_RST;
         arm_ff <= '0;
      end else begin
         en_ff  <= nxt_en;
         arm_ff <= nxt_arm;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         direct_ff <= HSIE_MODE_RST;
         mask_ff   <= HSIE_MASK_RST;
      end else if (wr_done) begin
         if (hit_mode) begin
            direct_ff <= pwdata[HSIE_MODE_DIRECT_BIT];
         end
         if (hit_mask) begin
            mask_ff <= wr_en_bits;
         end
      end
   end

   // ----------------------------------------
   // Host requests and local interrupt
   // ----------------------------------------
   // Index 3: IRQ10, 2: IRQ9, 1: IRQ6 from channel 3; index 0: IRQ11 from channel 2
   logic [3:0] nxt_req, req_rise;

   always_comb begin
      if (direct_ff) begin
         nxt_req = en_ff;
      end else begin
         nxt_req = en_ff & obf_vec;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_ff <= '0;
      end else begin
         req_ff <= nxt_req;
      end
   end

   assign req_rise = nxt_req & ~req_ff;

   // A new request in the cycle of a clearing read is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_ff <= HSIE_STAT_RST;
         irq     <= 1'b0;
      end else begin
         if (rd_done && hit_stat) begin
            stat_ff <= req_rise;
         end else begin
            stat_ff <= stat_ff | req_rise;
         end
         irq <= |(stat_ff & mask_ff);
      end
   end

   // ----------------------------------------
   // Serial IRQ frame
   // ----------------------------------------
   // Continuous mode only: this end never starts a frame itself
   hsie_frame_t state_ff, nxt_state;
   logic        lclk_prev_ff, tick, own_slot, own_req;
   logic [3:0]  low_cnt_ff, nxt_low_cnt, slot_ff, nxt_slot;
   logic [1:0]  phase_ff, nxt_phase;

   assign tick = lclk_s & ~lclk_prev_ff;

   always_comb begin
      nxt_state   = state_ff;
      nxt_low_cnt = low_cnt_ff;
      nxt_slot    = slot_ff;
      nxt_phase   = phase_ff;
      if (tick) begin
         unique case (state_ff)
            HSIE_FR_IDLE: begin
               if (!sio_s) begin
                  if (low_cnt_ff != HSIE_LAST_SLOT) begin
                     nxt_low_cnt = low_cnt_ff + 4'h1;
                  end
               end else begin
                  nxt_low_cnt = '0;
                  if (low_cnt_ff >= HSIE_START_MIN_CLKS) begin
                     nxt_state = HSIE_FR_TURN;
                  end
               end
            end
            HSIE_FR_TURN: begin
               nxt_state = HSIE_FR_SLOTS;
               nxt_slot  = '0;
               nxt_phase = '0;
            end
            HSIE_FR_SLOTS: begin
               if (phase_ff != HSIE_SLOT_LAST_PHASE) begin
                  nxt_phase = phase_ff + 2'h1;
               end else if (slot_ff == HSIE_LAST_SLOT) begin
                  nxt_state = HSIE_FR_IDLE;
               end else begin
                  nxt_phase = '0;
                  nxt_slot  = slot_ff + 4'h1;
               end
            end
         endcase
      end
      if (lpc_rst_s) begin
         nxt_state   = HSIE_FR_IDLE;
         nxt_low_cnt = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff     <= HSIE_FR_IDLE;
         lclk_prev_ff <= 1'b0;
         low_cnt_ff   <= '0;
         slot_ff      <= '0;
         phase_ff     <= '0;
      end else begin
         state_ff     <= nxt_state;
         lclk_prev_ff <= lclk_s;
         low_cnt_ff   <= nxt_low_cnt;
         slot_ff      <= nxt_slot;
         phase_ff     <= nxt_phase;
      end
   end

   always_comb begin
      own_slot = 1'b1;
      unique case (nxt_slot)
         HSIE_SLOT_INT10: own_req = req_ff[3];
         HSIE_SLOT_INT9:  own_req = req_ff[2];
         HSIE_SLOT_INT6:  own_req = req_ff[1];
         HSIE_SLOT_INT11: own_req = req_ff[0];
         default: begin
            own_req  = 1'b0;
            own_slot = 1'b0;
         end
      endcase
   end

   // Sample phase: low for an idle line, then one high recovery clock;
   // a pending request leaves the line to the pull-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serirq_o  <= 1'b1;
         serirq_oe <= 1'b0;
      end else if (lpc_rst_s) begin
         serirq_o  <= 1'b1;
         serirq_oe <= 1'b0;
      end else if (tick) begin
         if (nxt_state == HSIE_FR_SLOTS && own_slot && nxt_phase == 2'h0) begin
            serirq_o  <= 1'b0;
            serirq_oe <= ~own_req;
         end else if (nxt_state == HSIE_FR_SLOTS && nxt_phase == 2'h1) begin
            serirq_o  <= 1'b1;
         end else begin
            serirq_o  <= 1'b1;
            serirq_oe <= 1'b0;
         end
      end
   end

endmodule

/* File: tb/hsie_props.sv */
// Port checker for hsie_top: APB answer timing and serial line drive.
// Assumes one pclk domain, bound to hsie_top below.
`timescale 1ns/1ps
module hsie_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        lpc_reset_n,
   input wire logic        serirq_o,
   input wire logic        serirq_oe,
   input wire logic        irq
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy_time; psel && !penable |=> pready; endproperty
   a_rdy_time: assert property (p_rdy_time) else $error("no ready after setup");
   property p_rdy_pulse; pready |=> !pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
   property p_no_rdy; !psel |=> !pready; endproperty
   a_no_rdy: assert property (p_no_rdy) else $error("ready without select");
   property p_err; psel && !penable && paddr > 8'h0c |=> pready && pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_ok; psel && !penable && paddr <= 8'h0c && paddr[1:0] == 2'h0 |=> !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("mapped refused");
   property p_rd0; pready && pslverr |-> prdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("refused read not zero");
   property p_oe_low; $rose(serirq_oe) |-> !serirq_o ##1 serirq_oe [*8]; endproperty
   a_oe_low: assert property (p_oe_low) else $error("slot drive wrong");
   property p_oe_rel; $fell(serirq_oe) |-> $past(serirq_o); endproperty
   a_oe_rel: assert property (p_oe_rel) else $error("released while low");
   property p_lrst; (!lpc_reset_n) [*7] |-> !serirq_oe; endproperty
   a_lrst: assert property (p_lrst) else $error("line held in reset");
   c_err: cover property (pready && pslverr);
   c_slot: cover property ($rose(serirq_oe));
   c_irq: cover property ($rose(irq));
endmodule
bind hsie_top hsie_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .lpc_reset_n(lpc_reset_n), .serirq_o(serirq_o),
   .serirq_oe(serirq_oe), .irq(irq));

/* File: tb/hsie_host_model.sv */
// Host side of the serial interrupt line: start pulse, link clock, slot capture.
// Assumes the bench resolves the line with a pull-up.
`timescale 1ns/1ps
module hsie_host_model (
   output logic       lclk,
   output logic       host_low,
   input  wire logic  line,
   output logic [3:0] pend
);
   // ----------------------------------------
   // Frame
   // ----------------------------------------
   initial begin
      lclk = 0;
      host_low = 0;
      pend = 0;
   end
   // Clock stands still between frames; odd offset keeps it apart from pclk
   task automatic run_frame;
      #1.3;
      host_low = 1;
      for (int t = 0; t < 54; t++) begin
         lclk = 1;
         #80;
         lclk = 0;
         if (t >= 5 && (t - 5) % 3 == 0) begin
            case ((t - 5) / 3)
               11: pend[0] = line;
               6: pend[1] = line;
               9: pend[2] = line;
               10: pend[3] = line;
               default: ;
            endcase
         end
         host_low = (t < 3);
         #80;
      end
   endtask
endmodule

/* File: tb/host_serial_irq_enables_bench.sv */
// Self-checking bench for hsie_top against a small reference model.
// Assumes hsie_host_model on the serial line and APB at 200 MHz.
`timescale 1ns/1ps
module host_serial_irq_enables_bench;
   import hsie_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        f3 = 0, f2 = 0, lpc_reset_n = 1, lpc_sw_reset = 0, mode_m = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, serirq_o, serirq_oe, irq, lclk, host_low, line;
   logic [3:0]  pend, en_m = 0, arm_m = 0, stat_m = 0;
   logic [1:0]  fm = 0;
   int          fails = 0, checked = 0, seed = 32'h9a35bfdb;
   assign line = !(host_low || (serirq_oe && !serirq_o));
   hsie_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .out_buffer_full_ch3(f3), .out_buffer_full_ch2(f2), .lpc_reset_n(lpc_reset_n),
      .lpc_sw_reset(lpc_sw_reset), .lclk(lclk), .serirq_i(line), .serirq_o(serirq_o),
      .serirq_oe(serirq_oe), .irq(irq));
   hsie_host_model i_host (.lclk(lclk), .host_low(host_low), .line(line), .pend(pend));
   initial forever #2.5 pclk = ~pclk;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [3:0] req;
      req = mode_m ? en_m : en_m & {fm[1], fm[1], fm[1], fm[0]};
   endfunction
   // Request stands until the edge that samples pready high; values read
   // right after that edge are the ones it sampled, so the answer is taken there
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, exp, input logic err);
      int n = 0;
      logic [31:0] r;
      logic e;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
         if (n > 20) begin
            fails++;
            tally_and_finish();
         end
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      if (!w) chk("prdata", r, exp);
      chk("pslverr", e, err);
   endtask
   task automatic ctrl_rd;
      acc(0, HSIE_OFS_CTRL, 0, {25'h0, en_m, 3'h0}, 0);
      arm_m = arm_m | ~en_m;
   endtask
   task automatic ctrl_wr(input logic [3:0] v);
      logic [3:0] o;
      o = req();
      acc(1, HSIE_OFS_CTRL, {25'h0, v, 3'h0}, 0, 0);
      en_m = (en_m & v) | (v & arm_m);
      arm_m = 0;
      stat_m |= req() & ~o;
   endtask
   task automatic flags(input logic n3, input logic n2);
      logic [3:0] o;
      o = req();
      if (!mode_m) en_m &= ~{{3{fm[1] & !n3}}, fm[0] & !n2};
      fm = {n3, n2};
      stat_m |= req() & ~o;
      @(posedge pclk);
      f3 <= n3;
      f2 <= n2;
      repeat (4) @(posedge pclk);
   endtask
   task automatic frame;
      i_host.run_frame();
      chk("slots", pend, req());
   endtask
   task automatic lres(input logic hw);
      @(posedge pclk);
      if (hw) lpc_reset_n <= 0;
      else lpc_sw_reset <= 1;
      repeat (8) @(posedge pclk);
      lpc_reset_n <= 1;
      lpc_sw_reset <= 0;
      repeat (8) @(posedge pclk);
      en_m = 0;
      arm_m = 0;
      ctrl_rd;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      for (int i = 0; i < 16; i += 4) acc(0, 8'(i), 0, 0, 0);
      acc(0, 8'h10, 0, 0, 1);
      $display("test reset done");
      // The reset reads armed every bit; this write consumes the arms
      ctrl_wr(4'h0);
      ctrl_wr(4'hf);
      ctrl_rd;
      ctrl_wr(4'hf);
      ctrl_rd;
      ctrl_wr(4'h0);
      ctrl_rd;
      flags(1, 1);
      frame;
      for (int i = 0; i < 4; i++) begin
         ctrl_rd;
         ctrl_wr(4'(1 << i));
         frame;
         r = $random(seed);
         flags(r[0], r[1]);
         frame;
         flags(0, 0);
         ctrl_rd;
         flags(1, 1);
      end
      chk("irq", irq, 0);
      acc(0, HSIE_OFS_STAT, 0, {25'h0, stat_m, 3'h0}, 0);
      stat_m = 0;
      $display("test flag mode done");
      acc(1, HSIE_OFS_MODE, 1, 0, 0);
      mode_m = 1;
      flags(0, 0);
      ctrl_rd;
      ctrl_wr(4'hf);
      repeat (3) @(posedge pclk);
      chk("irq", irq, 0);
      acc(1, HSIE_OFS_MASK, 32'h78, 0, 0);
      repeat (3) @(posedge pclk);
      chk("irq", irq, 1);
      frame;
      acc(0, HSIE_OFS_STAT, 0, {25'h0, stat_m, 3'h0}, 0);
      stat_m = 0;
      repeat (3) @(posedge pclk);
      chk("irq", irq, 0);
      $display("test direct mode done");
      lres(0);
      ctrl_wr(4'hf);
      lres(1);
      acc(0, HSIE_OFS_MODE, 0, 1, 0);
      $display("test lpc reset done");
      tally_and_finish();
   end
endmodule
